/* File: bench/adc_analog_model.sv */
`timescale 1ns/1ps
// Input multiplexer and comparator seen from the sequencer
module adc_analog_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Channel select and activity from the sequencer
  input wire logic [2:0] analog_input_channel,
  input wire logic conv_active,
  // Input level of channel 0, each channel one step higher
  input wire logic [9:0] level_base,
  // Approximation register value
  output logic [9:0] sar_value
);
  // One cycle of settling; when idle the value toggles, never stays valid
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      sar_value <= 10'h155;
    else if (conv_active)
      sar_value <= level_base + {7'h00, analog_input_channel};
    else
      sar_value <= ~sar_value;
endmodule

/* File: bench/test_adc_sequencer.sv */
`timescale 1ns/1ps
module test_adc_sequencer;
  logic clk_sys, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, conv_active, conv_irq, irq_ack;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [2:0] analog_input_channel, ch;
  logic [9:0] sar_value, level_base;
  logic [31:0] exp_res [8];
  logic [31:0] cfg [4] = '{32'h003, 32'h1a3, 32'h643, 32'h7e3};
  int nt [4] = '{28, 33, 49, 33};
  int dv [4] = '{4, 2, 1, 1};
  int errors, n_tests, irq_hits, i, c, cyc, tot;

  adc_sequencer adc_sequencer_inst (.clk_sys(clk_sys), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .analog_input_channel(analog_input_channel),
    .conv_active(conv_active), .sar_value(sar_value),
    .conv_irq(conv_irq), .irq_ack(irq_ack));

  adc_analog_model adc_analog_model_inst (.clk_sys(clk_sys), .rst(rst),
    .analog_input_channel(analog_input_channel),
    .conv_active(conv_active), .level_base(level_base),
    .sar_value(sar_value));

  // Source clock, 25 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Fixed wait that counts interrupt request cycles
  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge clk_sys);
      if (conv_irq !== 1'b0) irq_hits++;
    end
    @(posedge clk_sys);
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw, w, b;
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 50; k++)
    begin
      @(negedge clk_sys);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b === 1'b1)
      begin
        bready <= 1'b0;
        return;
      end
    end
    errors++;
    tally_and_finish();
  endtask

  // Read: address held until taken, data taken with rvalid
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar, v;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 50; k++)
    begin
      @(negedge clk_sys);
      ar = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ar) arvalid <= 1'b0;
      if (v === 1'b1)
      begin
        rready <= 1'b0;
        return;
      end
    end
    errors++;
    tally_and_finish();
  endtask

  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, irq_ack} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    level_base = 10'h2a0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // Unmapped place refused both ways
    axi_rd(8'h10, rd, rsp);
    check(rd, 32'h0);
    check(32'(rsp), 32'(adc_seq_pkg::RESP_SLVERR));
    axi_wr(8'h10, 32'h1, rsp);
    check(rsp, adc_seq_pkg::RESP_SLVERR);
    $display("bus test done");
    // Repeat on channel 5, undivided, 8-bit
    axi_wr(adc_seq_pkg::CTRL_OFS, 32'h215, rsp);
    irq_hits = 0;
    idle(100);
    check(analog_input_channel, 3'h5);
    axi_rd(adc_seq_pkg::RESULT_BASE_OFS + 8'h14, rd, rsp);
    check(rd, 32'h2a5);
    axi_rd(adc_seq_pkg::RESULT_BASE_OFS + 8'h10, rd, rsp);
    check(rd, 32'h0);
    level_base <= 10'h1c0;
    idle(70);
    axi_rd(adc_seq_pkg::RESULT_BASE_OFS + 8'h14, rd, rsp);
    check(rd, 32'h1c5);
    axi_rd(adc_seq_pkg::CTRL_OFS, rd, rsp);
    check(rd[0], 1'b1);
    check(32'(rsp), 32'(adc_seq_pkg::RESP_OKAY));
    check(32'(irq_hits), 32'h0);
    axi_wr(adc_seq_pkg::CTRL_OFS, 32'h0, rsp);
    idle(4);
    check(conv_active, 1'b0);
    $display("repeat test done");
    for (c = 0; c < 8; c++) exp_res[c] = (c == 5) ? 32'h1c5 : 32'h0;
    // Sweeps over each group, divider, resolution; hold at 40 MHz
    for (i = 0; i < 4; i++)
    begin
      level_base <= 10'(64 * (i + 1));
      for (c = 0; c <= 2 * i + 1; c++) exp_res[c] = 64 * (i + 1) + c;
      axi_wr(adc_seq_pkg::CTRL_OFS, cfg[i], rsp);
      ch = 3'h7;
      for (cyc = 0; cyc < 3000 && conv_irq !== 1'b1; cyc++)
      begin
        @(negedge clk_sys);
        if (conv_active === 1'b1 && ch == 3'h7) ch = analog_input_channel;
      end
      if (cyc >= 3000)
      begin
        errors++;
        tally_and_finish();
      end
      check(ch, 3'h0);
      // First enable 1..dv cycles in; request pin and loop add two
      tot = (2 * i + 2) * nt[i] * dv[i];
      check(32'(cyc >= tot - dv[i] + 3), 32'h1);
      check(32'(cyc <= tot + 2), 32'h1);
      axi_rd(adc_seq_pkg::CTRL_OFS, rd, rsp);
      check(rd[0], 1'b0);
      axi_rd(adc_seq_pkg::STATUS_OFS, rd, rsp);
      check(rd[1:0], 2'h1);
      for (c = 0; c < 8; c++)
      begin
        axi_rd(adc_seq_pkg::RESULT_BASE_OFS + 8'(4 * c), rd, rsp);
        check(rd, exp_res[c]);
      end
      if (i % 2 == 0)
      begin
        irq_ack <= 1'b1;
        @(posedge clk_sys);
        irq_ack <= 1'b0;
      end
      else
        axi_wr(adc_seq_pkg::STATUS_OFS, 32'h0, rsp);
      idle(3);
      check(conv_irq, 1'b0);
      $display("sweep test %0d done", i);
    end
    tally_and_finish();
  end
endmodule

/* File: design/adc_clk_div.sv */
`timescale 1ns/1ps
// Conversion clock enable: one pulse every 4, 2 or 1 source cycles
module adc_clk_div (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Division select
  input wire logic [1:0] div_sel,
  // One-cycle conversion clock enable
  output logic tick_q
);

  logic [1:0] cnt_q;
  logic [1:0] last;
  logic wrap;

  // Terminal count of the selected ratio
  assign last = (div_sel == adc_seq_pkg::DIV_BY4) ? adc_seq_pkg::DIV_LAST4 :
                (div_sel == adc_seq_pkg::DIV_BY2) ? adc_seq_pkg::DIV_LAST2 :
                2'h0;
  assign wrap = (cnt_q >= last);

  // Free-running divider
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 2'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= wrap ? 2'h0 : cnt_q + 2'h1;
      tick_q <= wrap;
    end
  end

  // An enable, then the divide-by-4 ratio held through the whole gap
  sequence by4_run;
    tick_q && div_sel == adc_seq_pkg::DIV_BY4 ##1
      (div_sel == adc_seq_pkg::DIV_BY4) [*3];
  endsequence

  chk_div_by_four: assert property (@(posedge clk_sys) disable iff (rst)
    by4_run |=> tick_q && !$past(tick_q) && !$past(tick_q, 2) &&
      !$past(tick_q, 3))
    else $error("Divide-by-4 enable spacing wrong");

endmodule

/* File: design/adc_seq_pkg.sv */
package adc_seq_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RESULT_BASE_OFS = 8'h20;
  localparam logic [7:0] RESULT_LAST_OFS = 8'h3c;

  // Data widths and channel count
  localparam int RES_W = 10;
  localparam int CHAN_W = 3;
  localparam int NUM_CHAN = 8;

  // Conversion length in conversion-clock cycles
  localparam logic [5:0] CONV_CYC_8B = 6'h1c;   // 28
  localparam logic [5:0] CONV_CYC_10B = 6'h21;  // 33
  localparam logic [5:0] CONV_CYC_SH_8B = 6'h31; // 49
  localparam logic [5:0] CONV_CYC_ONE = 6'h01;

  // Conversion clock divider selections
  localparam logic [1:0] DIV_BY4 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_LAST4 = 2'h3;
  localparam logic [1:0] DIV_LAST2 = 2'h1;

  // Sweep group selections: last channel of each group
  localparam logic [1:0] GRP_CH01 = 2'h0;
  localparam logic [1:0] GRP_CH03 = 2'h1;
  localparam logic [1:0] GRP_CH05 = 2'h2;
  localparam logic [2:0] LAST_CH01 = 3'h1;
  localparam logic [2:0] LAST_CH03 = 3'h3;
  localparam logic [2:0] LAST_CH05 = 3'h5;
  localparam logic [2:0] LAST_CH07 = 3'h7;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register layout, bit 0 first from the right
  typedef struct packed {
    logic [4:0] rsvd;
    logic sample_hold;
    logic [1:0] clk_div;
    logic res10;
    logic [1:0] group;
    logic [2:0] chan;
    logic sweep;
    logic start;
  } ctrl_t;

  localparam logic [15:0] CTRL_WR_MASK = 16'h07ff;
  localparam ctrl_t CTRL_RST = '0;

  // Sequencer states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CONV
  } seq_state_t;

endpackage

/* File: design/adc_sequencer.sv */
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - Conversion clock is source divided 4, 2, 1
// - Conversion takes 28 or 33 cycles by resolution
// - Repeat mode converts one chosen channel repeatedly
// - Writing start one begins repeat conversions
// - Repeat result overwrites that channel's result
// - Repeat completions never raise interrupt request
// - Repeat runs until software clears start
// - Sweep group is channels 0-1, 0-3, 0-5, 0-7
// - Sweep start converts channel 0 first
// - Sweep ascends, storing each channel's result
// - Last sweep channel sets interrupt request
// - Sweep end clears start and halts
// - Request clears on acceptance or software clear
// - Sample-and-hold makes 8-bit conversion 49 cycles
module adc_sequencer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Analog multiplexer and comparator
  output logic [2:0] analog_input_channel,
  output logic conv_active,
  input wire logic [9:0] sar_value,
  // Interrupt request bit and its acceptance
  output logic conv_irq,
  input wire logic irq_ack
);

  adc_seq_pkg::ctrl_t ctrl_q;
  adc_seq_pkg::seq_state_t state_q;
  logic [9:0] result_q [adc_seq_pkg::NUM_CHAN];
  logic [2:0] chan_q;
  logic [5:0] cnt_q;
  logic irq_q;
  logic tick;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Conversion clock enable
  adc_clk_div adc_clk_div_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .div_sel(ctrl_q.clk_div),
    .tick_q(tick)
  );

  // Write decode, performed once both address and data are held
  logic wr_go;
  logic wr_ctrl;
  logic wr_status;
  logic wr_ok;
  logic [15:0] ctrl_wr_val;
  assign wr_go = !awready && !wready && !bvalid;
  assign wr_ctrl = wr_go && (aw_addr_q == adc_seq_pkg::CTRL_OFS);
  assign wr_status = wr_go && (aw_addr_q == adc_seq_pkg::STATUS_OFS);
  assign wr_ok = (aw_addr_q == adc_seq_pkg::CTRL_OFS) ||
                 (aw_addr_q == adc_seq_pkg::STATUS_OFS);
  assign ctrl_wr_val = {w_strb_q[1] ? w_data_q[15:8] : ctrl_q[15:8],
                        w_strb_q[0] ? w_data_q[7:0] : ctrl_q[7:0]} &
                       adc_seq_pkg::CTRL_WR_MASK;

  // Conversion length and sweep end channel
  logic [5:0] conv_len;
  logic [2:0] last_chan;
  logic done;
  logic last_done;
  assign conv_len = ctrl_q.res10 ? adc_seq_pkg::CONV_CYC_10B :
                    ctrl_q.sample_hold ? adc_seq_pkg::CONV_CYC_SH_8B :
                    adc_seq_pkg::CONV_CYC_8B;
  assign last_chan =
    (ctrl_q.group == adc_seq_pkg::GRP_CH01) ? adc_seq_pkg::LAST_CH01 :
    (ctrl_q.group == adc_seq_pkg::GRP_CH03) ? adc_seq_pkg::LAST_CH03 :
    (ctrl_q.group == adc_seq_pkg::GRP_CH05) ? adc_seq_pkg::LAST_CH05 :
    adc_seq_pkg::LAST_CH07;
  assign done = (state_q == adc_seq_pkg::ST_CONV) && ctrl_q.start && tick &&
                (cnt_q == conv_len - adc_seq_pkg::CONV_CYC_ONE);
  assign last_done = done && ctrl_q.sweep && (chan_q == last_chan);

  // Control register: software writes, sweep end clears start
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctrl_q <= adc_seq_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= ctrl_wr_val;
    else if (last_done)
      ctrl_q.start <= 1'b0;
  end

  // Interrupt request: set wins over acceptance and software clear
  logic irq_clr;
  assign irq_clr = irq_ack || (wr_status && w_strb_q[0] && !w_data_q[0]);
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_q <= 1'b0;
    else if (last_done)
      irq_q <= 1'b1;
    else if (irq_clr)
      irq_q <= 1'b0;
  end

  // Conversion sequencer
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= adc_seq_pkg::ST_IDLE;
      chan_q <= 3'h0;
      cnt_q <= 6'h00;
    end
    else
    begin
      case (state_q)
        adc_seq_pkg::ST_IDLE:
        begin
          cnt_q <= 6'h00;
          if (ctrl_q.start)
          begin
            state_q <= adc_seq_pkg::ST_CONV;
            chan_q <= ctrl_q.sweep ? 3'h0 : ctrl_q.chan;
          end
        end
        adc_seq_pkg::ST_CONV:
        begin
          if (!ctrl_q.start)
            state_q <= adc_seq_pkg::ST_IDLE;
          else if (done)
          begin
            cnt_q <= 6'h00;
            if (last_done)
              state_q <= adc_seq_pkg::ST_IDLE;
            else if (ctrl_q.sweep)
              chan_q <= chan_q + 3'h1;
            else
              chan_q <= ctrl_q.chan;
          end
          else if (tick)
            cnt_q <= cnt_q + 6'h01;
        end
        default: state_q <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Result capture, one register per channel
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < adc_seq_pkg::NUM_CHAN; i++)
        result_q[i] <= 10'h000;
    end
    else if (done)
      result_q[chan_q] <= sar_value;
  end

  // Pin outputs to the multiplexer, and the interrupt request pin
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      analog_input_channel <= 3'h0;
      conv_active <= 1'b0;
      conv_irq <= 1'b0;
    end
    else
    begin
      analog_input_channel <= chan_q;
      conv_active <= (state_q == adc_seq_pkg::ST_CONV) && ctrl_q.start;
      conv_irq <= irq_q;
    end
  end

  // Write channels: take address and data in either order, then respond
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= adc_seq_pkg::RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_go)
      begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read decode
  logic [31:0] rd_val;
  logic rd_ok;
  logic is_res;
  logic [2:0] res_idx;
  assign is_res = (araddr >= adc_seq_pkg::RESULT_BASE_OFS) &&
                  (araddr <= adc_seq_pkg::RESULT_LAST_OFS) &&
                  (araddr[1:0] == 2'h0);
  assign res_idx = araddr[4:2];
  assign rd_ok = is_res || (araddr == adc_seq_pkg::CTRL_OFS) ||
                 (araddr == adc_seq_pkg::STATUS_OFS);
  assign rd_val =
    (araddr == adc_seq_pkg::CTRL_OFS) ? {16'h0000, ctrl_q} :
    (araddr == adc_seq_pkg::STATUS_OFS) ?
      {27'h0000000, chan_q, conv_active, irq_q} :
    is_res ? {22'h000000, result_q[res_idx]} : 32'h0000_0000;

  // Read channels: answer one cycle after the address is taken
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= adc_seq_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= rd_ok ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Helper: enables seen since the current conversion began
  logic [5:0] ticks_q;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ticks_q <= 6'h00;
    else if (state_q != adc_seq_pkg::ST_CONV || done)
      ticks_q <= 6'h00;
    else if (tick)
      ticks_q <= ticks_q + 6'h01;
  end

  sequence sweep_step;
    done && ctrl_q.sweep && !last_done && !wr_ctrl;
  endsequence
  sequence sweep_end;
    last_done && !wr_ctrl;
  endsequence

  chk_conv_length: assert property (@(posedge clk_sys) disable iff (rst)
    done && !ctrl_q.sample_hold |-> ticks_q + adc_seq_pkg::CONV_CYC_ONE ==
      (ctrl_q.res10 ? adc_seq_pkg::CONV_CYC_10B : adc_seq_pkg::CONV_CYC_8B))
    else $error("Conversion length wrong");

  chk_sh_length: assert property (@(posedge clk_sys) disable iff (rst)
    done && ctrl_q.sample_hold && !ctrl_q.res10 |-> ticks_q ==
      adc_seq_pkg::CONV_CYC_SH_8B - adc_seq_pkg::CONV_CYC_ONE)
    else $error("Sample-and-hold length wrong");
  chk_repeat_chan: assert property (@(posedge clk_sys) disable iff (rst)
    done && !ctrl_q.sweep && !wr_ctrl |=> chan_q == $past(ctrl_q.chan))
    else $error("Repeat channel changed");

  chk_result_store: assert property (@(posedge clk_sys) disable iff (rst)
    done |=> result_q[$past(chan_q)] == $past(sar_value))
    else $error("Result not stored");

  chk_repeat_no_irq: assert property (@(posedge clk_sys) disable iff (rst)
    done && !ctrl_q.sweep |=> !$rose(irq_q))
    else $error("Repeat raised request");

  chk_repeat_start: assert property (@(posedge clk_sys) disable iff (rst)
    done && !ctrl_q.sweep && !wr_ctrl |=> ctrl_q.start &&
      state_q == adc_seq_pkg::ST_CONV)
    else $error("Repeat stopped by itself");

  chk_sweep_first: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == adc_seq_pkg::ST_IDLE && ctrl_q.start && ctrl_q.sweep
      |=> chan_q == 3'h0)
    else $error("Sweep did not start at channel 0");

  chk_sweep_order: assert property (@(posedge clk_sys) disable iff (rst)
    sweep_step |=> chan_q == $past(chan_q) + 3'h1)
    else $error("Sweep order wrong");

  chk_sweep_end: assert property (@(posedge clk_sys) disable iff (rst)
    sweep_end |=> irq_q && !ctrl_q.start ##1
      state_q == adc_seq_pkg::ST_IDLE && !conv_active)
    else $error("Sweep end not handled");

  chk_irq_clear: assert property (@(posedge clk_sys) disable iff (rst)
    irq_ack && !last_done |=> !irq_q ##1 !conv_irq)
    else $error("Request not cleared on acceptance");
endmodule
